/* design/eep_dev_end.sv */
// Purpose: memory target end of the two-wire link with 32K x 8 array
// Assumes: i_lclk samples the link far faster than the serial clock
`timescale 1ns/1ps
module eep_dev_end #(
  parameter int WR_CYC = eep_pkg::WR_CYC_DEF
) (
  // link clock and reset
  input  wire logic       i_lclk,
  input  wire logic       i_nrst,
  // two-wire link
  eep_if.dev              link,
  // strap and status
  input  wire logic [1:0] i_sel,
  output logic            o_busy
);
  import eep_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACK,
    S_TX,
    S_MACK,
    S_BUSY
  } eep_dst_t;

  typedef enum logic [1:0] {
    K_DEV,
    K_AHI,
    K_ALO,
    K_DATA
  } eep_kind_t;

  if (WR_CYC < PG_BYTES) begin : g_chk
    $error("eep_dev_end: write cycle shorter than one page commit");
  end

  // synchronised pins
  logic [3:0] sync_q;
  logic       scl_s;
  logic       sda_s;
  logic [1:0] sel_s;
  logic       scl_p;
  logic       sda_p;

  eep_sync2 #(.W(4)) u_sync (
    .i_clk  (i_lclk),
    .i_nrst (i_nrst),
    .i_d    ({link.scl, link.sda, i_sel}),
    .o_q    (sync_q)
  );

  assign scl_s = sync_q[3];
  assign sda_s = sync_q[2];
  assign sel_s = sync_q[1:0];

  // control state
  eep_dst_t            st_q;
  eep_kind_t           kind_q;
  logic [3:0]          cnt_q;
  logic [DATA_W-1:0]   sh_q;
  logic [DATA_W-2:0]   ahi_q;
  logic [ADDR_W-1:0]   addr_q;
  logic                wr_any_q;
  logic                drv_q;
  logic [31:0]         wcnt_q;
  logic [PG_BYTES-1:0] valid_q;

  // storage
  logic [DATA_W-1:0]   mem  [MEM_BYTES];
  logic [DATA_W-1:0]   pbuf [PG_BYTES];

  // decoded events
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic                dev_hit;
  logic                byte_in;
  logic                commit;
  logic                busy_end;
  logic                ack_end;
  logic                drv_d;
  logic [DATA_W-1:0]   rd_byte;
  logic [ADDR_W-1:0]   addr_inc;
  logic [ADDR_W-1:0]   page_inc;
  logic [PG_BITS-1:0]  widx;
  logic                wr_slot;

  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign dev_hit   = (sh_q[DATA_W-1:TYPE_LSB] == TYPE_ID)
                   && (sh_q[TYPE_LSB-1:SEL_LSB] == sel_s);
  assign byte_in   = (st_q == S_RX) && (cnt_q == ACK_SLOT);
  assign ack_end   = (st_q == S_ACK) && scl_fall;
  // a stop's own clock high may have shifted one bit already
  assign commit    = stop_det && wr_any_q && (st_q == S_RX) && (cnt_q[3:1] == 3'h0);
  assign busy_end  = (st_q == S_BUSY) && (wcnt_q == 32'(WR_CYC - 1));
  assign rd_byte   = mem[addr_q];
  assign addr_inc  = addr_q + 15'h0001;
  assign page_inc  = {addr_q[ADDR_W-1:PG_BITS], addr_q[PG_BITS-1:0] + 6'h01};
  assign widx      = wcnt_q[PG_BITS-1:0];
  assign wr_slot   = (st_q == S_BUSY) && (wcnt_q < 32'(PG_BYTES)) && valid_q[widx];
  assign drv_d     = (st_q == S_ACK) || ((st_q == S_TX) && ~sh_q[DATA_W-1]);

  // pin drive, open drain only
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = drv_q;
  assign o_busy          = (st_q == S_BUSY);

  always_ff @(posedge i_lclk) begin
    if (!i_nrst) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      drv_q <= 1'b0;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      drv_q <= drv_d;
    end
  end

  // protocol engine
  always_ff @(posedge i_lclk) begin
    if (!i_nrst) begin
      st_q     <= S_IDLE;
      kind_q   <= K_DEV;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      ahi_q    <= 7'h00;
      addr_q   <= 15'h0000;
      wr_any_q <= 1'b0;
    end else if (st_q == S_BUSY) begin
      if (busy_end) begin
        st_q <= S_IDLE;
      end
    end else if (start_det) begin
      st_q     <= S_RX;
      kind_q   <= K_DEV;
      cnt_q    <= 4'h0;
      wr_any_q <= 1'b0;
    end else if (stop_det) begin
      st_q     <= commit ? S_BUSY : S_IDLE;
      wr_any_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_RX: begin
          if (scl_rise && !byte_in) begin
            sh_q  <= {sh_q[DATA_W-2:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (scl_fall && byte_in) begin
            st_q <= (kind_q != K_DEV || dev_hit) ? S_ACK : S_IDLE;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            st_q  <= S_RX;
            cnt_q <= 4'h0;
            unique case (kind_q)
              K_DEV: begin
                if (sh_q[RW_BIT]) begin
                  st_q   <= S_TX;
                  sh_q   <= rd_byte;
                  addr_q <= addr_inc;
                end else begin
                  kind_q <= K_AHI;
                end
              end
              K_AHI: begin
                ahi_q  <= sh_q[DATA_W-2:0];
                kind_q <= K_ALO;
              end
              K_ALO: begin
                addr_q <= {ahi_q, sh_q};
                kind_q <= K_DATA;
              end
              K_DATA: begin
                wr_any_q <= 1'b1;
                addr_q   <= page_inc;
              end
            endcase
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_q == BIT_LAST) begin
              st_q <= S_MACK;
            end else begin
              sh_q  <= {sh_q[DATA_W-2:0], 1'b1};
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise && sda_s) begin
            st_q <= S_IDLE;
          end else if (scl_fall) begin
            st_q   <= S_TX;
            sh_q   <= rd_byte;
            addr_q <= addr_inc;
            cnt_q  <= 4'h0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // write cycle timer
  always_ff @(posedge i_lclk) begin
    if (!i_nrst) begin
      wcnt_q <= 32'h0;
    end else begin
      wcnt_q <= (st_q == S_BUSY) ? wcnt_q + 32'h1 : 32'h0;
    end
  end

  // page buffer load and slot tracking
  always_ff @(posedge i_lclk) begin
    if (!i_nrst) begin
      valid_q <= '0;
    end else if (ack_end && kind_q == K_ALO) begin
      valid_q <= '0;
    end else if (ack_end && kind_q == K_DATA) begin
      valid_q[addr_q[PG_BITS-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge i_lclk) begin
    if (ack_end && kind_q == K_DATA) begin
      pbuf[addr_q[PG_BITS-1:0]] <= sh_q;
    end
  end

  // commit one loaded slot per cycle during the write cycle
  always_ff @(posedge i_lclk) begin
    if (wr_slot) begin
      mem[{addr_q[ADDR_W-1:PG_BITS], widx}] <= pbuf[widx];
    end
  end
endmodule

/* design/eep_pkg.sv */
// Purpose: shared constants and types for the two-wire serial memory link
// Assumes: 32K x 8 array, 64-byte pages, link sample clock of 12 ns
// Notes:   timing counts are derived from the times below
package eep_pkg;

  // array geometry
  localparam int ADDR_W    = 15;
  localparam int MEM_BYTES = 2 ** ADDR_W;
  localparam int PG_BITS   = 6;
  localparam int PG_BYTES  = 2 ** PG_BITS;
  localparam int DATA_W    = 8;

  // target address byte layout
  localparam logic [3:0] TYPE_ID  = 4'hA;
  localparam int         TYPE_LSB = 4;
  localparam int         SEL_LSB  = 2;
  localparam int         RW_BIT   = 0;

  // bit slots within one nine-clock byte
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // self-timed write cycle on the link sample clock, rounded up
  localparam int T_WR_NS    = 5000000;
  localparam int LCLK_NS    = 12;
  localparam int WR_CYC_DEF = (T_WR_NS + LCLK_NS - 1) / LCLK_NS;

  // controller clock divider, quarter of one serial clock period
  localparam int MCLK_HZ = 250000000;
  localparam int SCL_HZ  = 250000;
  localparam int QTR_DEF = MCLK_HZ / (4 * SCL_HZ);

  // per-quarter wire levels, index = quarter number
  localparam logic [3:0] SCL_PAT_BIT   = 4'h6;
  localparam logic [3:0] SCL_PAT_STOP  = 4'hE;
  localparam logic [3:0] SDA_PAT_START = 4'h3;
  localparam logic [3:0] SDA_PAT_STOP  = 4'hC;

  typedef enum logic [1:0] {
    EEP_OP_START,
    EEP_OP_STOP,
    EEP_OP_WRITE,
    EEP_OP_READ
  } eep_op_t;

endpackage

/* design/eep_if.sv */
// Purpose: two-wire link between controller and memory target
// Assumes: open-drain data line with pull-up, controller drives clock
// Notes:   data level is the wired-and of both pull-downs
`timescale 1ns/1ps
interface eep_if;
  logic scl;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic sda;

  // pull-up wins unless a party drives low
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface

/* design/eep_sync2.sv */
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels relative to i_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module eep_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("eep_sync2: width must be at least one");
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

/* design/eep_host_end.sv */
// Purpose: bus controller end, drives serial clock and frames bytes
// Assumes: one command at a time, start before bytes, stop to finish
// Notes:   serial clock is i_mclk divided by four quarters of QTR
`timescale 1ns/1ps
module eep_host_end #(
  parameter int QTR = eep_pkg::QTR_DEF
) (
  // clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_nrst,
  // two-wire link
  eep_if.host                       link,
  // command
  input  wire logic                 i_cmd_valid,
  input  wire eep_pkg::eep_op_t     i_cmd_op,
  input  wire logic [7:0]           i_cmd_data,
  input  wire logic                 i_cmd_nack,
  output logic                      o_cmd_ready,
  // response
  output logic                      o_rsp_valid,
  output logic [7:0]                o_rsp_data,
  output logic                      o_rsp_ack
);
  import eep_pkg::*;

  if (QTR < 16 || QTR > 65535) begin : g_chk
    $error("eep_host_end: quarter count out of range");
  end

  logic        act_q;
  eep_op_t     op_q;
  logic [1:0]  q_q;
  logic [15:0] div_q;
  logic [3:0]  bit_q;
  logic [8:0]  sh_q;
  logic [7:0]  rx_q;
  logic        ack_q;
  logic        rsp_q;
  logic        scl_q;
  logic        sda_q;
  logic        sda_s;
  logic        is_byte;
  logic        last_bit;
  logic        q_end;
  logic [3:0]  scl_pat;
  logic        sda_lvl;

  eep_sync2 #(.W(1)) u_sync (
    .i_clk  (i_mclk),
    .i_nrst (i_nrst),
    .i_d    (link.sda),
    .o_q    (sda_s)
  );

  assign is_byte  = (op_q == EEP_OP_WRITE) || (op_q == EEP_OP_READ);
  assign last_bit = is_byte ? (bit_q == ACK_SLOT) : 1'b1;
  assign q_end    = (div_q == 16'(QTR - 1));
  assign scl_pat  = (op_q == EEP_OP_STOP) ? SCL_PAT_STOP : SCL_PAT_BIT;
  assign sda_lvl  = (op_q == EEP_OP_START) ? SDA_PAT_START[q_q]
                  : (op_q == EEP_OP_STOP)  ? SDA_PAT_STOP[q_q] : sh_q[8];

  assign o_cmd_ready      = ~act_q;
  assign o_rsp_valid      = rsp_q;
  assign o_rsp_data       = rx_q;
  assign o_rsp_ack        = ack_q;
  assign link.scl         = scl_q;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = ~sda_q;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      act_q <= 1'b0;
      op_q  <= EEP_OP_STOP;
      q_q   <= 2'h0;
      div_q <= 16'h0;
      bit_q <= 4'h0;
      sh_q  <= 9'h1FF;
      rx_q  <= 8'h00;
      ack_q <= 1'b0;
      rsp_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      rsp_q <= 1'b0;
      if (!act_q) begin
        if (i_cmd_valid) begin
          act_q <= 1'b1;
          op_q  <= i_cmd_op;
          q_q   <= 2'h0;
          div_q <= 16'h0;
          bit_q <= 4'h0;
          // read leaves data released; ninth bit is our ack or nack
          sh_q  <= (i_cmd_op == EEP_OP_READ) ? {8'hFF, i_cmd_nack} : {i_cmd_data, 1'b1};
        end
      end else begin
        scl_q <= scl_pat[q_q];
        sda_q <= sda_lvl;
        if (q_end) begin
          div_q <= 16'h0;
          q_q   <= q_q + 2'h1;
          if (q_q == 2'h2 && bit_q <= BIT_LAST) begin
            rx_q <= {rx_q[6:0], sda_s};
          end
          if (q_q == 2'h2 && bit_q == ACK_SLOT) begin
            ack_q <= ~sda_s;
          end
          if (q_q == 2'h3) begin
            sh_q  <= {sh_q[7:0], 1'b1};
            bit_q <= bit_q + 4'h1;
            if (last_bit) begin
              act_q <= 1'b0;
              rsp_q <= is_byte;
            end
          end
        end else begin
          div_q <= div_q + 16'h1;
        end
      end
    end
  end
endmodule

/* tb/eep_link_sva.sv */
// Purpose: link checker for the two-wire memory pair
// Assumes: device domain clock samples the link
// Notes:   busy length counted in device clocks
`timescale 1ns/1ps
module eep_link_sva #(
  parameter int WR_CYC = 400
) (
  // clock and reset
  input  wire logic i_lclk,
  input  wire logic i_nrst,
  // link and status
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic host_sda_oe,
  input  wire logic dev_sda_oe,
  input  wire logic o_busy
);
  int busy_cnt_q;
  int busy_cnt_d;
  assign busy_cnt_d = o_busy ? busy_cnt_q + 1 : 0;
  always_ff @(posedge i_lclk) begin
    if (!i_nrst) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  default clocking cb @(posedge i_lclk); endclocking
  default disable iff (!i_nrst);
  property p_busy_hiz;
    o_busy |-> !dev_sda_oe;
  endproperty
  a_busy_hiz: assert property (p_busy_hiz) else $error("data driven while busy");
  property p_busy_stop;
    $rose(o_busy) |-> scl && sda;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("busy began outside a stop");
  property p_busy_len;
    $fell(o_busy) |-> busy_cnt_q >= WR_CYC - 1 && busy_cnt_q <= WR_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_poll;
    $rose(o_busy) |-> !dev_sda_oe [*8];
  endproperty
  a_poll: assert property (p_poll) else $error("acknowledge while busy");
  property p_chg_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_chg_low: assert property (p_chg_low) else $error("data changed with clock high");
  property p_no_clash;
    $rose(scl) |-> !(host_sda_oe && dev_sda_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
  property p_rst_idle;
    $rose(i_nrst) |-> !o_busy && !dev_sda_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  property p_busy_hold;
    $rose(o_busy) |=> o_busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("write cycle cut short");
endmodule

/* tb/serial_eeprom_rw_protocol_test.sv */
// Purpose: self-checking bench for controller and memory ends
// Assumes: short write cycle and fast serial clock
// Notes:   select strap 2, target byte A8
`timescale 1ns/1ps
module serial_eeprom_rw_protocol_test;
  import eep_pkg::*;
  localparam int         QTR_T = 16;
  localparam int         WR_T  = 400;
  localparam logic [7:0] TGT   = 8'hA8;
  logic          i_mclk      = 1'b0;
  logic          i_lclk      = 1'b0;
  logic          i_nrst      = 1'b0;
  logic          i_cmd_valid = 1'b0;
  logic          i_cmd_nack  = 1'b0;
  eep_op_t       i_cmd_op    = EEP_OP_START;
  logic [7:0]    i_cmd_data  = 8'h00;
  logic [1:0]    i_sel       = 2'h2;
  logic          o_busy;
  logic          o_cmd_ready;
  logic          o_rsp_valid;
  logic [7:0]    o_rsp_data;
  logic          o_rsp_ack;
  int            n_fail      = 0;
  int            total_checks = 0;
  int            np;
  logic [14:0]   r_addr[4]   = '{15'h0000, 15'h7FFF, 15'h1234, 15'h2ABC};
  logic [7:0]    r_dat[4]    = '{8'h3C, 8'hC3, 8'h5A, 8'hA5};
  logic [7:0]    bad[2]      = '{8'hAC, 8'hB8};
  eep_if link_if();
  eep_dev_end #(.WR_CYC(WR_T)) eep_dev_end_inst (.i_lclk(i_lclk), .i_nrst(i_nrst), .link(link_if.dev),
    .i_sel(i_sel), .o_busy(o_busy));
  eep_host_end #(.QTR(QTR_T)) eep_host_end_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .link(link_if.host),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_data(i_cmd_data), .i_cmd_nack(i_cmd_nack),
    .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_rsp_ack(o_rsp_ack));
  eep_link_sva #(.WR_CYC(WR_T)) eep_link_sva_inst (.i_lclk(i_lclk), .i_nrst(i_nrst), .scl(link_if.scl),
    .sda(link_if.sda), .host_sda_oe(link_if.host_sda_oe), .dev_sda_oe(link_if.dev_sda_oe), .o_busy(o_busy));
  initial forever #2 i_mclk = ~i_mclk;
  initial begin
    #5;
    forever #6 i_lclk = ~i_lclk;
  end
  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic op(input eep_op_t o, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    @(negedge i_mclk);
    i_cmd_valid = 1'b1;
    i_cmd_op = o;
    i_cmd_data = d;
    i_cmd_nack = nk;
    @(negedge i_mclk);
    i_cmd_valid = 1'b0;
    while (o_cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge i_mclk);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      finish_test();
    end
    chk("rsp_valid", {7'h00, o_rsp_valid}, {7'h00, o == EEP_OP_WRITE || o == EEP_OP_READ});
  endtask
  task automatic setaddr(input logic [14:0] a);
    op(EEP_OP_START, 8'h00, 1'b0);
    op(EEP_OP_WRITE, TGT, 1'b0);
    op(EEP_OP_WRITE, {1'b0, a[14:8]}, 1'b0);
    op(EEP_OP_WRITE, a[7:0], 1'b0);
    chk("addr_ack", {7'h00, o_rsp_ack}, 8'h01);
  endtask
  // repeated start then read-direction target
  task automatic rdstart();
    op(EEP_OP_START, 8'h00, 1'b0);
    op(EEP_OP_WRITE, TGT | 8'h01, 1'b0);
    chk("rd_tgt_ack", {7'h00, o_rsp_ack}, 8'h01);
  endtask
  task automatic rd(input logic nk, input logic [7:0] exp);
    op(EEP_OP_READ, 8'hFF, nk);
    chk("rd_data", o_rsp_data, exp);
  endtask
  task automatic poll();
    np = 0;
    do begin
      op(EEP_OP_START, 8'h00, 1'b0);
      op(EEP_OP_WRITE, TGT, 1'b0);
      np++;
    end while (o_rsp_ack !== 1'b1 && np < 40);
    chk("poll_nack_first", {7'h00, np > 1}, 8'h01);
    chk("poll_done", {7'h00, o_rsp_ack}, 8'h01);
  endtask
  initial begin
    repeat (20) @(negedge i_mclk);
    i_nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      setaddr(r_addr[i]);
      op(EEP_OP_WRITE, r_dat[i], 1'b0);
      chk("data_ack", {7'h00, o_rsp_ack}, 8'h01);
      op(EEP_OP_STOP, 8'h00, 1'b0);
      chk("busy", {7'h00, o_busy}, 8'h01);
      poll();
      op(EEP_OP_WRITE, {1'b0, r_addr[i][14:8]}, 1'b0);
      op(EEP_OP_WRITE, r_addr[i][7:0], 1'b0);
      rdstart();
      rd(1'b1, r_dat[i]);
      op(EEP_OP_STOP, 8'h00, 1'b0);
    end
    // sequential read across the top of the array
    setaddr(15'h7FFF);
    rdstart();
    rd(1'b0, 8'hC3);
    rd(1'b1, 8'h3C);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    // address only then stop: no write, counter loaded
    setaddr(15'h1234);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    repeat (200) @(negedge i_mclk);
    chk("no_busy", {7'h00, o_busy}, 8'h00);
    rdstart();
    rd(1'b1, 8'h5A);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    // wrong type or select bits
    for (int i = 0; i < 2; i++) begin
      op(EEP_OP_START, 8'h00, 1'b0);
      op(EEP_OP_WRITE, bad[i], 1'b0);
      chk("bad_tgt_ack", {7'h00, o_rsp_ack}, 8'h00);
      op(EEP_OP_STOP, 8'h00, 1'b0);
    end
    // select strap moved to three, same byte now matches
    i_sel = 2'h3;
    op(EEP_OP_START, 8'h00, 1'b0);
    op(EEP_OP_WRITE, bad[0], 1'b0);
    chk("sel_tgt_ack", {7'h00, o_rsp_ack}, 8'h01);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    i_sel = 2'h2;
    // page write of 65 bytes from slot 62 of page 5
    setaddr(15'h017E);
    for (int k = 0; k < 65; k++) begin
      op(EEP_OP_WRITE, 8'(k + 1), 1'b0);
    end
    chk("page_ack", {7'h00, o_rsp_ack}, 8'h01);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    poll();
    rdstart();
    rd(1'b1, 8'h02);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    setaddr(15'h017D);
    rdstart();
    rd(1'b0, 8'h40);
    rd(1'b0, 8'h41);
    rd(1'b1, 8'h02);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    // second reset in mid-run
    @(negedge i_mclk);
    i_nrst = 1'b0;
    repeat (20) @(negedge i_mclk);
    i_nrst = 1'b1;
    @(negedge i_mclk);
    chk("rst_idle", {4'h0, o_cmd_ready, o_busy, link_if.scl, link_if.sda}, 8'h0B);
    // link still works after the reset
    setaddr(15'h2ABC);
    rdstart();
    rd(1'b1, 8'hA5);
    op(EEP_OP_STOP, 8'h00, 1'b0);
    finish_test();
  end
endmodule
